/* File: src/mlc_pkg.sv */
// Constants and types shared by the message logic cell evaluator
package mlc_pkg;
	localparam int MSG_AW = 12;
	// Register map, byte addresses
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_SIDING = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_CELLS = 12'h00c;
	localparam logic [11:0] REG_CELL_BASE = 12'h100;
	localparam logic [1:0] CELL_WORD_OUT = 2'h3;
	// Control register fields
	localparam int CTRL_BASE_LSB = 0;
	localparam int CTRL_CFG_LSB = 8;
	localparam int CTRL_MSG_EN_BIT = 16;
	localparam int CTRL_SID_EN_BIT = 17;
	localparam int CTRL_CONT_EN_BIT = 18;
	localparam logic [7:0] BASE_RST = 8'h65;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic MSG_EN_RST = 1'b1;
	localparam int CFG_INVERT_ALL_BIT = 3;
	// Siding register fields
	localparam int SID_SW1_LSB = 0;
	localparam int SID_BLK2_LSB = 8;
	localparam int SID_BLK3_LSB = 16;
	localparam int SID_NRED_LSB = 24;
	// Element type fields
	localparam int TY_AND_BIT = 7;
	localparam int TY_TRUE_BIT = 6;
	localparam int TY_KIND_LSB = 4;
	localparam int TY_ADDER_LSB = 0;
	localparam int TY_ADDER_W = 4;
	localparam logic [3:0] ADDER_MAX = 4'h9;
	localparam logic [1:0] KSEL_SENSOR = 2'h2;
	localparam logic [1:0] KSEL_FEEDBACK = 2'h1;
	localparam logic [1:0] KSEL_SWITCH = 2'h0;
	// Output control fields
	localparam int OC_INV_BIT = 7;
	localparam int OC_EFF_LSB = 3;
	localparam int OC_RECIP_BIT = 2;
	localparam int OC_DUR_LSB = 0;
	localparam logic [1:0] EFF_NONE = 2'h0;
	localparam logic [1:0] EFF_DELAY = 2'h1;
	localparam logic [1:0] EFF_FLASH = 2'h2;
	localparam logic [1:0] EFF_DYN = 2'h3;
	// Siding aspect bits
	localparam int ASP_GREEN = 0;
	localparam int ASP_YELLOW = 1;
	localparam int ASP_RED = 2;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int FLASH_BASE_MS = 500;
	localparam int DELAY_BASE_MS = 5000;
	localparam int TICK_MS = FLASH_BASE_MS / 2;
	localparam int TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DELAY_BASE_TICKS = DELAY_BASE_MS / TICK_MS;

	typedef enum logic [1:0] {MLC_KIND_SWITCH, MLC_KIND_FEEDBACK, MLC_KIND_SENSOR} mlc_kind_t;
	typedef struct packed {
		logic [MSG_AW-1:0] addr;
		mlc_kind_t kind;
		logic state;
	} mlc_msg_t;
	typedef enum logic {MLC_EM_IDLE, MLC_EM_SEND} mlc_emit_t;
endpackage : mlc_pkg

/* File: src/mlc_evaluator.sv */
// Logic cell evaluator with siding signal logic and an APB register file
//
// Summary of operation
// R1: Second siding switch address is always the first switch address plus one.
// R2: Switches closed select block 3 occupancy for the signal; thrown select block 2.
// R3: Siding signal shows red, yellow or green, neighbour red address feeding yellow.
// R4: Switch messages from the bus update switch logic like local contacts do.
// R5: Lower-head siding lamps have no output here; others drive them.
// R6: Cell n message address is base address plus n minus one.
// R7: Each cell state is sent as a sensor message at the cell address.
// R8: Each element holds an 8-bit watched address, separate from its type.
// R9: Element type is a sum of fields, one choice per group.
// R10: Type 128 selects AND, 0 OR; 64 matches true state, 0 false.
// R11: Type 32 selects sensor, 16 feedback, 0 switch messages.
// R12: Adder field zero to nine, times 256, is added to the watched address.
// R13: False elements match throw or low; true elements match close or hi.
// R14: Cell is true when its AND elements and any OR element are satisfied.
// R15: Each cell has one output control setting shaping its output.
// R16: Outputs drive low when true; configuration option bit inverts all outputs.
// R17: Block detectors send hi sensor messages when a block becomes occupied.
// R18: A thrown command appears as a false switch message.
// R19: Two cells on one address, true and false, drive a motor pair.
// R20: Software must avoid circular cell references.
// R21: Output effects: 24 dynamic flash, 16 flash, 8 delay, 4 alternate flashing.
// R22: Duration zero to three sets flash rate and delay, only with an effect.
// R23: An element with address zero is unused and ignored.
`timescale 1ns/10ps
module mlc_evaluator #(
	parameter int NUM_CELLS = 24,
	parameter int TICK_CYC = mlc_pkg::TICK_CYC,
	parameter int ADDER_STEP = 256
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_prdata,
	// Messages received from the layout bus
	input wire logic i_msg_valid,
	input wire mlc_pkg::mlc_msg_t i_msg,
	// Cell state messages sent to the layout bus
	output logic o_msg_valid,
	input wire logic i_msg_ready,
	output mlc_pkg::mlc_msg_t o_msg,
	// Local siding switch contacts, asynchronous pins
	input wire logic [1:0] i_sw_contact,
	// Outputs
	output logic [NUM_CELLS-1:0] o_cell_out,
	output logic [2:0] o_siding_aspect
);
	localparam int AW = mlc_pkg::MSG_AW;
	localparam int CW = (NUM_CELLS > 1) ? $clog2(NUM_CELLS) : 1;
	localparam int TW = $clog2(TICK_CYC + 1);

	logic [7:0] base_q, cfg_q, sw1_q, blk2_q, blk3_q, nred_q;
	logic msg_en_q, sid_en_q, cont_en_q;
	logic [7:0] elem_addr_q [NUM_CELLS][3];
	logic [7:0] elem_type_q [NUM_CELLS][3];
	logic [7:0] out_ctl_q [NUM_CELLS];
	logic [2:0] elem_state_q [NUM_CELLS];
	logic [7:0] dly_q [NUM_CELLS];
	logic [7:0] sw2_addr;
	logic [NUM_CELLS-1:0] cell_true, dyn_c, pub_q, pend, act, cell_out_q;
	logic [1:0] contact_s1_q, contact_s2_q, contact_prev_q, contact_pend_q, contact_take;
	logic ext_valid, loop_fire, pick_any;
	mlc_pkg::mlc_msg_t ext_msg, out_q;
	mlc_pkg::mlc_emit_t em_q;
	logic [CW-1:0] pick_idx, out_idx_q;
	logic [1:0] sw_closed_q;
	logic blk2_occ_q, blk3_occ_q, nred_q_on, sel_occ;
	logic [2:0] aspect_q;
	logic [TW-1:0] tick_cnt_q;
	logic tick;
	logic [3:0] phase_q;
	logic setup, wr, addr_ok, cell_hit;
	logic [11:0] cell_off;
	logic [CW-1:0] cidx;
	logic [1:0] cword;
	logic [31:0] rd_data, prdata_q;
	logic pslverr_q;

	// R9 one choice per group; an unlisted code matches nothing
	// R11 message kind select
	function automatic logic kind_ok(input logic [7:0] t, input mlc_pkg::mlc_kind_t k);
		case (t[mlc_pkg::TY_KIND_LSB +: 2])
			mlc_pkg::KSEL_SENSOR: kind_ok = (k == mlc_pkg::MLC_KIND_SENSOR);
			mlc_pkg::KSEL_FEEDBACK: kind_ok = (k == mlc_pkg::MLC_KIND_FEEDBACK);
			mlc_pkg::KSEL_SWITCH: kind_ok = (k == mlc_pkg::MLC_KIND_SWITCH);
			default: kind_ok = 1'b0;
		endcase
	endfunction : kind_ok

	// R8 watched address; R12 adder widens it, R23 zero means unused
	function automatic logic elem_match(input logic [7:0] a, input logic [7:0] t, input mlc_pkg::mlc_msg_t m);
		logic [3:0] adder;
		logic [AW-1:0] watch;
		adder = t[mlc_pkg::TY_ADDER_LSB +: mlc_pkg::TY_ADDER_W];
		watch = {4'h0, a} + AW'(int'(adder) * ADDER_STEP);
		elem_match = (a != 8'h00) && (adder <= mlc_pkg::ADDER_MAX) && kind_ok(t, m.kind) && (m.addr == watch);
	endfunction : elem_match

	function automatic logic sens_hit(input logic [7:0] a, input mlc_pkg::mlc_msg_t m);
		sens_hit = (a != 8'h00) && (m.addr == {4'h0, a}) && (m.kind == mlc_pkg::MLC_KIND_SENSOR);
	endfunction : sens_hit

	function automatic logic sw_hit(input logic [7:0] a, input mlc_pkg::mlc_msg_t m);
		sw_hit = (a != 8'h00) && (m.addr == {4'h0, a}) && (m.kind != mlc_pkg::MLC_KIND_SENSOR);
	endfunction : sw_hit

	// APB decode; registers answer with no wait state
	assign setup = i_psel & ~i_penable;
	assign wr = i_psel & i_penable & i_pwrite;
	assign o_pready = 1'b1;
	assign o_prdata = prdata_q;
	assign o_pslverr = pslverr_q;
	assign cell_off = i_paddr - mlc_pkg::REG_CELL_BASE;
	assign cell_hit = (i_paddr >= mlc_pkg::REG_CELL_BASE) && (int'(cell_off[11:4]) < NUM_CELLS);
	assign cidx = CW'(cell_off[11:4]);
	assign cword = cell_off[3:2];
	// R1 switch two follows switch one
	assign sw2_addr = sw1_q + 8'h01;

	always_comb begin
		rd_data = 32'h0;
		addr_ok = 1'b1;
		if (cell_hit) begin
			if (cword == mlc_pkg::CELL_WORD_OUT) begin
				rd_data = {24'h0, out_ctl_q[cidx]};
			end else begin
				rd_data = {16'h0, elem_type_q[cidx][cword], elem_addr_q[cidx][cword]};
			end
		end else begin
			case (i_paddr)
				mlc_pkg::REG_CTRL: rd_data = {13'h0, cont_en_q, sid_en_q, msg_en_q, cfg_q, base_q};
				mlc_pkg::REG_SIDING: rd_data = {nred_q, blk3_q, blk2_q, sw1_q};
				mlc_pkg::REG_STATUS: rd_data = {16'h0, sw2_addr, aspect_q, nred_q_on, blk3_occ_q, blk2_occ_q, sw_closed_q};
				mlc_pkg::REG_CELLS: rd_data = 32'(cell_true);
				default: addr_ok = 1'b0;
			endcase
		end
	end

	// Read data is captured in the setup cycle so the access phase sees flops
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= i_pwrite ? 32'h0 : rd_data;
			pslverr_q <= ~addr_ok;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			base_q <= mlc_pkg::BASE_RST;
			cfg_q <= mlc_pkg::CFG_RST;
			msg_en_q <= mlc_pkg::MSG_EN_RST;
			sid_en_q <= 1'b0;
			cont_en_q <= 1'b0;
			sw1_q <= 8'h00;
			blk2_q <= 8'h00;
			blk3_q <= 8'h00;
			nred_q <= 8'h00;
			elem_addr_q <= '{default: '0};
			elem_type_q <= '{default: '0};
			out_ctl_q <= '{default: '0};
		end else if (wr && addr_ok) begin
			if (cell_hit) begin
				// R15 one output control per cell
				if (cword == mlc_pkg::CELL_WORD_OUT) begin
					out_ctl_q[cidx] <= i_pwdata[7:0];
				end else begin
					// R8 address and type are separate fields
					elem_addr_q[cidx][cword] <= i_pwdata[7:0];
					elem_type_q[cidx][cword] <= i_pwdata[15:8];
				end
			end else begin
				case (i_paddr)
					mlc_pkg::REG_CTRL: begin
						base_q <= i_pwdata[mlc_pkg::CTRL_BASE_LSB +: 8];
						cfg_q <= i_pwdata[mlc_pkg::CTRL_CFG_LSB +: 8];
						msg_en_q <= i_pwdata[mlc_pkg::CTRL_MSG_EN_BIT];
						sid_en_q <= i_pwdata[mlc_pkg::CTRL_SID_EN_BIT];
						cont_en_q <= i_pwdata[mlc_pkg::CTRL_CONT_EN_BIT];
					end
					mlc_pkg::REG_SIDING: begin
						sw1_q <= i_pwdata[mlc_pkg::SID_SW1_LSB +: 8];
						blk2_q <= i_pwdata[mlc_pkg::SID_BLK2_LSB +: 8];
						blk3_q <= i_pwdata[mlc_pkg::SID_BLK3_LSB +: 8];
						nred_q <= i_pwdata[mlc_pkg::SID_NRED_LSB +: 8];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Contact pins: two flops, then edge detection on the second
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			contact_s1_q <= 2'b00;
			contact_s2_q <= 2'b00;
			contact_prev_q <= 2'b00;
			contact_pend_q <= 2'b00;
		end else begin
			contact_s1_q <= i_sw_contact;
			contact_s2_q <= contact_s1_q;
			contact_prev_q <= contact_s2_q;
			// A new edge wins over the clear of an event being served
			contact_pend_q <= (contact_pend_q & ~contact_take) | ((contact_s2_q ^ contact_prev_q) & {2{cont_en_q}});
		end
	end

	// R4 contact events ride the same path as bus switch messages
	always_comb begin
		ext_valid = i_msg_valid;
		ext_msg = i_msg;
		contact_take = 2'b00;
		if (!i_msg_valid && contact_pend_q != 2'b00) begin
			ext_valid = 1'b1;
			ext_msg.kind = mlc_pkg::MLC_KIND_SWITCH;
			if (contact_pend_q[0]) begin
				ext_msg.addr = {4'h0, sw1_q};
				ext_msg.state = contact_s2_q[0];
				contact_take = 2'b01;
			end else begin
				ext_msg.addr = {4'h0, sw2_addr};
				ext_msg.state = contact_s2_q[1];
				contact_take = 2'b10;
			end
		end
	end

	// R13 element latches the last matching state; own sent states loop back
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			elem_state_q <= '{default: '0};
		end else begin
			for (int c = 0; c < NUM_CELLS; c++) begin
				for (int e = 0; e < 3; e++) begin
					if (ext_valid && elem_match(elem_addr_q[c][e], elem_type_q[c][e], ext_msg)) begin
						elem_state_q[c][e] <= ext_msg.state;
					end else if (loop_fire && elem_match(elem_addr_q[c][e], elem_type_q[c][e], out_q)) begin
						elem_state_q[c][e] <= out_q.state;
					end
				end
			end
		end
	end

	// R14 combine elements; R10 AND/OR and wanted state per element
	always_comb begin
		logic or_any;
		logic or_used;
		logic and_all;
		logic used;
		logic res;
		or_any = 1'b0;
		or_used = 1'b0;
		and_all = 1'b1;
		used = 1'b0;
		res = 1'b0;
		cell_true = '0;
		dyn_c = '0;
		for (int c = 0; c < NUM_CELLS; c++) begin
			or_any = 1'b0;
			or_used = 1'b0;
			and_all = 1'b1;
			used = 1'b0;
			for (int e = 0; e < 3; e++) begin
				// R23 unused element skipped
				if (elem_addr_q[c][e] != 8'h00) begin
					used = 1'b1;
					res = (elem_state_q[c][e] == elem_type_q[c][e][mlc_pkg::TY_TRUE_BIT]);
					if (elem_type_q[c][e][mlc_pkg::TY_AND_BIT]) begin
						and_all = and_all & res;
					end else begin
						or_used = 1'b1;
						or_any = or_any | res;
					end
				end
			end
			cell_true[c] = used & and_all & (or_any | ~or_used);
			dyn_c[c] = (elem_addr_q[c][2] != 8'h00)
				&& (elem_state_q[c][2] == elem_type_q[c][2][mlc_pkg::TY_TRUE_BIT]);
		end
	end

	// Lowest changed cell is sent first
	assign pend = cell_true ^ pub_q;
	always_comb begin
		pick_any = 1'b0;
		pick_idx = '0;
		for (int c = NUM_CELLS - 1; c >= 0; c--) begin
			if (pend[c]) begin
				pick_any = 1'b1;
				pick_idx = CW'(c);
			end
		end
	end

	assign loop_fire = (em_q == mlc_pkg::MLC_EM_SEND) && (i_msg_ready || !msg_en_q);
	assign o_msg_valid = (em_q == mlc_pkg::MLC_EM_SEND) && msg_en_q;
	assign o_msg = out_q;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			em_q <= mlc_pkg::MLC_EM_IDLE;
			out_q <= '0;
			out_idx_q <= '0;
			pub_q <= '0;
		end else begin
			case (em_q)
				mlc_pkg::MLC_EM_IDLE: begin
					if (pick_any) begin
						// R6 cell address from base; R7 sent as sensor message
						out_q.addr <= {4'h0, base_q + 8'(pick_idx)};
						out_q.kind <= mlc_pkg::MLC_KIND_SENSOR;
						out_q.state <= cell_true[pick_idx];
						out_idx_q <= pick_idx;
						pub_q[pick_idx] <= cell_true[pick_idx];
						em_q <= mlc_pkg::MLC_EM_SEND;
					end
				end
				mlc_pkg::MLC_EM_SEND: begin
					if (loop_fire) begin
						em_q <= mlc_pkg::MLC_EM_IDLE;
					end
				end
				default: em_q <= mlc_pkg::MLC_EM_IDLE;
			endcase
		end
	end

	// Siding trackers; R17 hi sensor means occupied, R18 false switch means thrown
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sw_closed_q <= 2'b00;
			blk2_occ_q <= 1'b0;
			blk3_occ_q <= 1'b0;
			nred_q_on <= 1'b0;
		end else begin
			// R4 bus switch or feedback message updates position
			if (ext_valid && sw_hit(sw1_q, ext_msg)) begin
				sw_closed_q[0] <= ext_msg.state;
			end
			if (ext_valid && sw_hit(sw2_addr, ext_msg)) begin
				sw_closed_q[1] <= ext_msg.state;
			end
			if (ext_valid && sens_hit(blk2_q, ext_msg)) begin
				blk2_occ_q <= ext_msg.state;
			end else if (loop_fire && sens_hit(blk2_q, out_q)) begin
				blk2_occ_q <= out_q.state;
			end
			if (ext_valid && sens_hit(blk3_q, ext_msg)) begin
				blk3_occ_q <= ext_msg.state;
			end else if (loop_fire && sens_hit(blk3_q, out_q)) begin
				blk3_occ_q <= out_q.state;
			end
			if (ext_valid && sens_hit(nred_q, ext_msg)) begin
				nred_q_on <= ext_msg.state;
			end else if (loop_fire && sens_hit(nred_q, out_q)) begin
				nred_q_on <= out_q.state;
			end
		end
	end

	// R2 both switches closed use block 3, otherwise block 2
	assign sel_occ = (&sw_closed_q) ? blk3_occ_q : blk2_occ_q;

	// R3 three-aspect head; R5 lower-head lamps are not driven from here
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aspect_q <= 3'b000;
		end else if (!sid_en_q) begin
			aspect_q <= 3'b000;
		end else begin
			aspect_q <= 3'b000;
			if (sel_occ) begin
				aspect_q[mlc_pkg::ASP_RED] <= 1'b1;
			end else if (nred_q_on) begin
				aspect_q[mlc_pkg::ASP_YELLOW] <= 1'b1;
			end else begin
				aspect_q[mlc_pkg::ASP_GREEN] <= 1'b1;
			end
		end
	end
	assign o_siding_aspect = aspect_q;

	// Quarter-second base tick: half the shortest flash period
	assign tick = (tick_cnt_q == TW'(TICK_CYC - 1));
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_q <= '0;
			phase_q <= 4'h0;
		end else if (tick) begin
			tick_cnt_q <= '0;
			phase_q <= phase_q + 4'h1;
		end else begin
			tick_cnt_q <= tick_cnt_q + TW'(1);
		end
	end

	// Delay counters run only while the cell is true and saturate
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dly_q <= '{default: '0};
		end else begin
			for (int c = 0; c < NUM_CELLS; c++) begin
				if (!cell_true[c]) begin
					dly_q[c] <= 8'h00;
				end else if (tick && dly_q[c] != 8'hff) begin
					dly_q[c] <= dly_q[c] + 8'h01;
				end
			end
		end
	end

	// R21 effect select; R22 duration doubles flash period and delay per step
	always_comb begin
		logic [1:0] dur;
		logic flash;
		dur = 2'h0;
		flash = 1'b0;
		act = '0;
		for (int c = 0; c < NUM_CELLS; c++) begin
			dur = out_ctl_q[c][mlc_pkg::OC_DUR_LSB +: 2];
			flash = phase_q[dur] ^ out_ctl_q[c][mlc_pkg::OC_RECIP_BIT];
			case (out_ctl_q[c][mlc_pkg::OC_EFF_LSB +: 2])
				mlc_pkg::EFF_NONE: act[c] = cell_true[c];
				mlc_pkg::EFF_DELAY: act[c] = cell_true[c] && (dly_q[c] >= (8'(mlc_pkg::DELAY_BASE_TICKS) << dur));
				mlc_pkg::EFF_FLASH: act[c] = cell_true[c] & flash;
				// Element C alone turns steady into flashing
				mlc_pkg::EFF_DYN: act[c] = cell_true[c] & (dyn_c[c] ? flash : 1'b1);
				default: act[c] = cell_true[c];
			endcase
		end
	end

	// R16 active low by default; global and per-output inversion; R19 pairs are independent cells
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cell_out_q <= '1;
		end else begin
			for (int c = 0; c < NUM_CELLS; c++) begin
				cell_out_q[c] <= ~act[c] ^ cfg_q[mlc_pkg::CFG_INVERT_ALL_BIT] ^ out_ctl_q[c][mlc_pkg::OC_INV_BIT];
			end
		end
	end
	assign o_cell_out = cell_out_q;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	sw2_readback_a: assert property (setup && !i_pwrite && i_paddr == mlc_pkg::REG_STATUS |=> o_prdata[15:8] == $past(sw1_q) + 8'h01) else $error("switch two address not consecutive"); // R1
	siding_route_a: assert property (sid_en_q && (&sw_closed_q) && blk3_occ_q && !blk2_occ_q |=> o_siding_aspect[mlc_pkg::ASP_RED]) else $error("closed siding ignores block three"); // R2
	aspect_onehot_a: assert property (sid_en_q |=> $onehot(o_siding_aspect) || !$past(sid_en_q)) else $error("siding aspect not single"); // R3
	bus_switch_a: assert property (i_msg_valid && i_msg.kind == mlc_pkg::MLC_KIND_SWITCH && sw1_q != 8'h00 && i_msg.addr == {4'h0, sw1_q} |=> sw_closed_q[0] == $past(i_msg.state)) else $error("bus switch message lost"); // R4
	cell_addr_a: assert property (o_msg_valid |-> o_msg.addr[7:0] == base_q + 8'(out_idx_q) && o_msg.kind == mlc_pkg::MLC_KIND_SENSOR) else $error("cell message address wrong"); // R6
	msg_hold_a: assert property (o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable(o_msg)) else $error("cell message dropped before accept"); // R7
	elem_latch_a: assert property (i_msg_valid && elem_match(elem_addr_q[0][0], elem_type_q[0][0], i_msg) |=> elem_state_q[0][0] == $past(i_msg.state)) else $error("element missed its message"); // R13
	unused_cell_a: assert property (elem_addr_q[0][0] == 8'h00 && elem_addr_q[0][1] == 8'h00 && elem_addr_q[0][2] == 8'h00 |-> !cell_true[0]) else $error("empty cell reads true"); // R23
	out_polarity_a: assert property (cell_true[0] && out_ctl_q[0] == 8'h00 && !cfg_q[mlc_pkg::CFG_INVERT_ALL_BIT] |=> !o_cell_out[0]) else $error("true cell output not low"); // R16
	delay_hold_a: assert property (cell_true[0] && dly_q[0] == 8'h00 && out_ctl_q[0][7:3] == {3'b000, mlc_pkg::EFF_DELAY} && !cfg_q[mlc_pkg::CFG_INVERT_ALL_BIT] |=> o_cell_out[0]) else $error("delay output turned on early"); // R22
	apb_ready_a: assert property (i_psel && i_penable |-> o_pready && o_pslverr == $past(!addr_ok)) else $error("apb access not answered");

	msg_sent_c: cover property (o_msg_valid && i_msg_ready);
	siding_thrown_c: cover property (sid_en_q && !(&sw_closed_q) && blk2_occ_q);
	flash_toggle_c: cover property (cell_true[0] && $changed(o_cell_out[0]));
	contact_event_c: cover property (contact_take != 2'b00);
endmodule : mlc_evaluator

/* File: bench/mlc_bus_node.sv */
// Far-side layout bus node: sends messages to the evaluator and takes its cell messages
`timescale 1ns/10ps
module mlc_bus_node (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Requests from the bench
	input wire logic i_send,
	input wire mlc_pkg::mlc_msg_t i_tx,
	input wire logic i_slow,
	// Evaluator side
	output logic o_valid,
	output mlc_pkg::mlc_msg_t o_msg,
	output logic o_cell_ready
);
	logic [1:0] wait_q;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_valid <= 1'b0;
			o_msg <= '0;
		end else begin
			o_valid <= i_send;
			// Idle lines keep changing so a stale message never looks valid
			o_msg <= i_send ? i_tx : ~o_msg;
		end
	end
	// Slow mode takes one cycle in four
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			wait_q <= 2'h0;
		else
			wait_q <= wait_q + 2'h1;
	end
	assign o_cell_ready = !i_slow || (wait_q == 2'h0);
endmodule : mlc_bus_node

/* File: bench/testbench.sv */
// Self-checking bench for the message logic cell evaluator
`timescale 1ns/10ps
module testbench;
	logic i_clock, i_rst_n, psel, penable, pwrite, o_pready, o_pslverr, send, slow, mvalid, o_msg_valid, rdy, err, c, lst;
	logic [11:0] paddr;
	logic [31:0] pwdata, o_prdata, q;
	logic [23:0] o_cell_out;
	logic [2:0] o_siding_aspect;
	logic [15:0] rnd;
	logic [7:0] a, ea[3], et[3];
	logic [3:0] ad;
	logic [1:0] k, cont;
	mlc_pkg::mlc_msg_t tx, mmsg, o_msg;
	int errors, checks, nmsg;
	bit st[int];
	mlc_evaluator #(.TICK_CYC(4)) i_mlc_evaluator (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_msg_valid(mvalid), .i_msg(mmsg),
		.o_msg_valid(o_msg_valid), .i_msg_ready(rdy), .o_msg(o_msg), .i_sw_contact(cont),
		.o_cell_out(o_cell_out), .o_siding_aspect(o_siding_aspect));
	mlc_bus_node i_mlc_bus_node (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_send(send), .i_tx(tx),
		.i_slow(slow), .o_valid(mvalid), .o_msg(mmsg), .o_cell_ready(rdy));
	task close_out;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task apb(input logic w, input logic [11:0] ad_i, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad_i;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			close_out();
		end
		q = o_prdata;
		err = o_pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task cfg(input int e, input logic [7:0] ar, input logic [7:0] ty);
		ea[e] = ar;
		et[e] = ty;
		apb(1'b1, 12'h100 + 12'(4 * e), {16'h0, ty, ar});
	endtask : cfg
	task msg(input logic [1:0] kk, input logic [11:0] ma, input logic s);
		@(posedge i_clock);
		send <= 1'b1;
		tx <= '{addr: ma, kind: mlc_pkg::mlc_kind_t'(kk), state: s};
		st[kk * 4096 + ma] = s;
		@(posedge i_clock);
		send <= 1'b0;
		repeat (2) @(posedge i_clock);
		#1;
	endtask : msg
	function automatic logic cell_eval();
		bit used, andok, orhit, hasor, s;
		int key;
		andok = 1;
		for (int e = 0; e < 3; e++) begin
			key = et[e][5:4] * 4096 + ea[e] + et[e][3:0] * 256;
			s = (st.exists(key) ? st[key] : 1'b0) == et[e][6];
			if (ea[e] != 0) begin
				used = 1;
				if (et[e][7])
					andok &= s;
				else begin
					hasor = 1;
					orhit |= s;
				end
			end
		end
		return used && andok && (orhit || !hasor);
	endfunction : cell_eval
	task chk_out;
		c = cell_eval();
		cmp(o_cell_out[0], {31'h0, ~c});
		apb(1'b0, mlc_pkg::REG_CELLS, 32'h0);
		cmp(q[0], {31'h0, c});
	endtask : chk_out
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	always @(posedge i_clock) begin
		if (o_msg_valid === 1'b1 && rdy === 1'b1) begin
			nmsg++;
			lst = o_msg.state;
			cmp({17'h0, o_msg}, {17'h0, 12'h065, mlc_pkg::MLC_KIND_SENSOR, o_msg.state});
		end
	end
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	initial begin
		{i_rst_n, psel, penable, pwrite, send, slow, paddr, pwdata, tx, cont} = '0;
		rnd = 16'd34955;
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		apb(1'b0, mlc_pkg::REG_CTRL, 32'h0);
		cmp(q, 32'h0001_0065);
		apb(1'b0, 12'hffc, 32'h0);
		cmp({31'h0, err}, 32'h1);
		cfg(0, 8'd1, 8'h60);
		cfg(1, 8'd61, 8'h00);
		cfg(2, 8'd0, 8'h00);
		msg(2'h0, 12'd61, 1'b1);
		msg(2'h2, 12'd1, 1'b0);
		chk_out();
		msg(2'h2, 12'd1, 1'b1);
		chk_out();
		msg(2'h2, 12'd1, 1'b0);
		msg(2'h0, 12'd61, 1'b0);
		chk_out();
		cfg(1, 8'd0, 8'h00);
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			a = rnd[7:0] % 8'd100 + 8'd1; // never the cell's own address
			k = rnd[9:8] % 2'd3;
			ad = rnd[13:10] % 4'd10;
			slow <= rnd[0];
			cfg(0, a, {rnd[15], rnd[14], k, ad});
			msg(k, {4'h0, a} + {ad, 8'h00}, rnd[2]);
			chk_out();
		end
		cfg(0, 8'd7, 8'h60);
		msg(2'h2, 12'd7, 1'b1);
		apb(1'b1, mlc_pkg::REG_CELL_BASE + 12'h00c, 32'h8);
		msg(2'h2, 12'd7, 1'b0);
		msg(2'h2, 12'd7, 1'b1);
		cmp(o_cell_out[0], 32'h1);
		// Delay of duration zero, with the bench tick of four cycles
		repeat (mlc_pkg::DELAY_BASE_TICKS * 4 + 8) @(posedge i_clock);
		cmp(o_cell_out[0], 32'h0);
		apb(1'b1, mlc_pkg::REG_SIDING, 32'h7d03_0232);
		apb(1'b1, mlc_pkg::REG_CTRL, 32'h0007_0065);
		cont <= 2'b10;
		msg(2'h0, 12'd50, 1'b1);
		msg(2'h2, 12'd3, 1'b1);
		cmp(o_siding_aspect, 32'h4);
		apb(1'b0, mlc_pkg::REG_STATUS, 32'h0);
		cmp(q, 32'h0000_338b);
		msg(2'h0, 12'd50, 1'b0);
		msg(2'h2, 12'd125, 1'b1);
		cmp(o_siding_aspect, 32'h2);
		chk_out();
		apb(1'b1, mlc_pkg::REG_CTRL, 32'h0001_0865);
		apb(1'b0, mlc_pkg::REG_CELLS, 32'h0);
		cmp(o_cell_out[0], {31'h0, c});
		cmp({31'h0, nmsg > 0}, 32'h1);
		cmp({31'h0, lst}, {31'h0, c});
		close_out();
	end
endmodule : testbench
